// >>> include/hcr_pkg.sv
// constants for the hibernation clock and refresh block
// assumes a 50 MHz system clock and an 8-bit chip-select-link code bus
package hcr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned CODE_W = 8;
	localparam logic [7:0] CODE_ENTER_HIB = 8'h15;
	localparam logic [7:0] CODE_EXIT_HIB = 8'h16;
	localparam int unsigned REFRESH_PERIOD_NS = 122100;
	localparam int unsigned REFRESH_PULSE_NS = 1000;
	// longest time rounds down, least time rounds up
	localparam int unsigned REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned REFRESH_PULSE_CYC = (REFRESH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 16;
	localparam logic RST_HIB = 1'b0;
	localparam logic RST_SEL_SLOW = 1'b0;
endpackage

// >>> rtl/hcr_top.sv
// hibernation clock switch and dram keepalive strobe generator
// assumes both oscillators and the code bus are asynchronous pins; the code
// must be stable before chip_select_link_valid rises and until it falls
// How it works
// - code 15H with a valid strobe puts the block into hibernation.
// - code 16H with a valid strobe takes the block out of hibernation.
// - in hibernation, a 1.0 us strobe pulse starts every 122.1 us.
// - the keepalive strobe stays low whenever hibernation is not active.
// - outside hibernation the companion clock follows the 14.318 MHz oscillator.
// - in hibernation the companion clock follows the 32.768 kHz oscillator.
module hcr_top #(
	parameter int unsigned REFRESH_PERIOD_CYC = hcr_pkg::REFRESH_PERIOD_CYC,
	parameter int unsigned REFRESH_PULSE_CYC = hcr_pkg::REFRESH_PULSE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// oscillators
	input wire logic fast_osc_in,
	input wire logic slow_osc_in,
	// chip-select-link decoder input
	input wire logic [hcr_pkg::CODE_W-1:0] chip_select_link_code,
	input wire logic chip_select_link_valid,
	// outputs
	output logic companion_clock_out,
	output logic fast_crystal_out,
	output logic dram_keepalive_strobe,
	output logic hibernate_active
);
	import hcr_pkg::*;

	if (REFRESH_PULSE_CYC < 1 || REFRESH_PULSE_CYC + 1 >= REFRESH_PERIOD_CYC || REFRESH_PERIOD_CYC > 65535) begin
		$error("hcr_top: refresh counts out of range");
	end

	localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(REFRESH_PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0] PULSE_LEN = CNT_W'(REFRESH_PULSE_CYC);

	// two-stage synchronisers for the oscillator, code and valid pins; rst is not synchronised
	logic [1:0] osc_ff1_q;
	logic [1:0] osc_s_q;
	logic [CODE_W-1:0] code_ff1_q;
	logic [CODE_W-1:0] code_s_q;
	logic valid_ff1_q;
	logic valid_s_q;
	logic valid_d_q;
	always_ff @(posedge clk_sys) begin
		osc_ff1_q <= {slow_osc_in, fast_osc_in};
		osc_s_q <= osc_ff1_q;
		code_ff1_q <= chip_select_link_code;
		code_s_q <= code_ff1_q;
		valid_ff1_q <= chip_select_link_valid;
		valid_s_q <= valid_ff1_q;
		valid_d_q <= valid_s_q;
	end

	logic fast_s;
	logic slow_s;
	logic code_take;
	logic enter_hit;
	logic exit_hit;
	assign fast_s = osc_s_q[0];
	assign slow_s = osc_s_q[1];
	assign code_take = valid_s_q && !valid_d_q;
	assign enter_hit = code_take && (code_s_q == CODE_ENTER_HIB);
	assign exit_hit = code_take && (code_s_q == CODE_EXIT_HIB);

	// hibernation mode
	logic hib_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hib_q <= RST_HIB;
		end else if (enter_hit) begin
			hib_q <= 1'b1;
		end else if (exit_hit) begin
			hib_q <= 1'b0;
		end
	end

	// clock source select: only changes while the output and both sources are low, so no partial pulse
	logic sel_slow_q;
	logic clk_out_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_slow_q <= RST_SEL_SLOW;
		end else if (sel_slow_q != hib_q && !clk_out_q && !fast_s && !slow_s) begin
			sel_slow_q <= hib_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_out_q <= 1'b0;
		end else if (sel_slow_q) begin
			clk_out_q <= slow_s;
		end else begin
			clk_out_q <= fast_s;
		end
	end

	logic fast_out_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fast_out_q <= 1'b0;
		end else begin
			fast_out_q <= fast_s;
		end
	end

	// refresh period counter, held at zero outside hibernation
	logic [CNT_W-1:0] cnt_q;
	logic strobe_q;
	always_ff @(posedge clk_sys) begin
		if (rst || !hib_q) begin
			cnt_q <= '0;
		end else if (cnt_q == PERIOD_LAST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= hib_q && (cnt_q < PULSE_LEN) && !exit_hit;
		end
	end

	// length of the current keepalive pulse, counted apart from the period counter for the checks
	logic [CNT_W-1:0] hi_len_q;
	always_ff @(posedge clk_sys) begin
		if (rst || !strobe_q) begin
			hi_len_q <= '0;
		end else begin
			hi_len_q <= hi_len_q + CNT_W'(1);
		end
	end

	assign companion_clock_out = clk_out_q;
	assign fast_crystal_out = fast_out_q;
	assign dram_keepalive_strobe = strobe_q;
	assign hibernate_active = hib_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_enter;
		enter_hit |=> hib_q;
	endproperty
	a_enter: assert property (p_enter) else $error("entry code did not start hibernation");

	property p_exit;
		exit_hit |=> !hib_q && !dram_keepalive_strobe;
	endproperty
	a_exit: assert property (p_exit) else $error("exit code did not end hibernation");

	property p_pulse_len;
		$fell(dram_keepalive_strobe) && hib_q |-> cnt_q == PULSE_LEN + CNT_W'(1) && hi_len_q == PULSE_LEN;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("keepalive pulse has wrong length");

	property p_period;
		(hib_q && cnt_q == PERIOD_LAST && !exit_hit) ##1 !exit_hit |-> cnt_q == '0 ##1 dram_keepalive_strobe;
	endproperty
	a_period: assert property (p_period) else $error("keepalive period wrong");

	property p_idle;
		!hib_q |-> !dram_keepalive_strobe;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe active outside hibernation");

	property p_fast;
		!sel_slow_q |=> companion_clock_out == $past(fast_s);
	endproperty
	a_fast: assert property (p_fast) else $error("fast clock not passed through");

	property p_slow;
		sel_slow_q |=> companion_clock_out == $past(slow_s);
	endproperty
	a_slow: assert property (p_slow) else $error("slow clock not passed through");

	property p_glitch;
		$changed(sel_slow_q) |-> !companion_clock_out && !$past(companion_clock_out);
	endproperty
	a_glitch: assert property (p_glitch) else $error("clock switched while high");

	property p_reset;
		$fell(rst) |-> !hib_q && !sel_slow_q && !dram_keepalive_strobe;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

	property p_strobe_start;
		$rose(hib_q) && !exit_hit |=> dram_keepalive_strobe;
	endproperty
	a_strobe_start: assert property (p_strobe_start) else $error("keepalive pulse did not start on entry");

	property p_pulse_max;
		dram_keepalive_strobe |-> hi_len_q < PULSE_LEN;
	endproperty
	a_pulse_max: assert property (p_pulse_max) else $error("keepalive pulse too long");

	property p_hold_mode;
		!enter_hit && !exit_hit |=> $stable(hib_q);
	endproperty
	a_hold_mode: assert property (p_hold_mode) else $error("mode changed without a code");

	property p_code_ignored;
		code_take && code_s_q != CODE_ENTER_HIB && code_s_q != CODE_EXIT_HIB |=> $stable(hib_q);
	endproperty
	a_code_ignored: assert property (p_code_ignored) else $error("unknown code changed the mode");

	property p_fast_xtal;
		1'b1 |=> fast_crystal_out == $past(fast_s);
	endproperty
	a_fast_xtal: assert property (p_fast_xtal) else $error("fast oscillator output not passed through");

	property p_sel_dir;
		$changed(sel_slow_q) |-> sel_slow_q == $past(hib_q) && !$past(fast_s) && !$past(slow_s);
	endproperty
	a_sel_dir: assert property (p_sel_dir) else $error("clock source switched at a wrong moment");

	c_enter: cover property (enter_hit ##1 hib_q);
	c_pulse: cover property ($rose(dram_keepalive_strobe));
	c_switch_slow: cover property ($rose(sel_slow_q));
	c_switch_fast: cover property ($fell(sel_slow_q));
	c_exit: cover property (exit_hit ##1 !hib_q);
endmodule

// >>> verif/hcr_far_model.sv
// oscillator sources for the block: fast crystal and slow timekeeping clock
// assumes both run free, unrelated in phase to the system clock
module hcr_far_model (
	// oscillators
	output logic fast_osc,
	output logic slow_osc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial fast_osc = 1'b0;
	initial slow_osc = 1'b0;
	always #34.921 fast_osc = ~fast_osc;
	always #15258.789 slow_osc = ~slow_osc;
endmodule

// >>> verif/tb.sv
// self-checking bench for hcr_top: mode codes, keepalive strobe, clock source
// assumes hcr_far_model supplies both oscillators
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hcr_pkg::*;
	localparam int PER = 40;
	localparam int PUL = 4;
	// fast oscillator rises per 1000 system clocks at 14.318 MHz
	localparam int FAST_PER_K = 286;
	// a slow half period (763 clocks) plus margin: the switch waits for both sources and the output to be low
	localparam int SLOW_SETTLE = 800;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic fast_osc_in, slow_osc_in, companion_clock_out, fast_crystal_out;
	logic dram_keepalive_strobe, hibernate_active;
	logic chip_select_link_valid = 1'b0;
	logic [CODE_W-1:0] chip_select_link_code = 8'h00;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	always #10 clk_sys = ~clk_sys;
	hcr_far_model hcr_far_model_inst (.fast_osc(fast_osc_in), .slow_osc(slow_osc_in));
	hcr_top #(.REFRESH_PERIOD_CYC(PER), .REFRESH_PULSE_CYC(PUL)) hcr_top_inst (.clk_sys(clk_sys), .rst(rst),
		.fast_osc_in(fast_osc_in), .slow_osc_in(slow_osc_in), .chip_select_link_code(chip_select_link_code),
		.chip_select_link_valid(chip_select_link_valid), .companion_clock_out(companion_clock_out),
		.fast_crystal_out(fast_crystal_out), .dram_keepalive_strobe(dram_keepalive_strobe),
		.hibernate_active(hibernate_active));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("mismatches=%0d checks=%0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// code held stable around the valid rise, valid low long enough after
	task automatic send(input logic [7:0] code);
		@(negedge clk_sys);
		chip_select_link_code = code;
		repeat (3) @(negedge clk_sys);
		chip_select_link_valid = 1'b1;
		repeat (5) @(negedge clk_sys);
		chip_select_link_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic t_reset();
		repeat (3) @(negedge clk_sys);
		chk(16'({companion_clock_out, fast_crystal_out, dram_keepalive_strobe, hibernate_active}), 16'h0000);
		rst = 1'b0;
	endtask
	task automatic t_clocks(input logic h, input int n);
		int r = 0;
		int f = 0;
		int s = 0;
		logic p;
		logic q;
		p = companion_clock_out;
		q = fast_crystal_out;
		repeat (n) begin
			@(negedge clk_sys);
			r += int'(companion_clock_out && !p);
			f += int'(fast_crystal_out && !q);
			s += int'(dram_keepalive_strobe);
			p = companion_clock_out;
			q = fast_crystal_out;
		end
		chk(16'(f >= n * FAST_PER_K / 1000 - 4 && f <= n * FAST_PER_K / 1000 + 4), 16'h0001);
		if (h) begin
			chk(16'(r >= 1 && r <= 2), 16'h0001);
			chk(16'(s), 16'(n / PER * PUL));
		end else begin
			chk(16'(r >= n * FAST_PER_K / 1000 - 4 && r <= n * FAST_PER_K / 1000 + 4), 16'h0001);
			chk(16'(s), 16'h0000);
		end
	endtask
	task automatic t_enter();
		int hi = 0;
		int lo = 0;
		int w = 0;
		send(8'h3A);
		chk(16'(hibernate_active), 16'h0000);
		send(CODE_ENTER_HIB);
		chk(16'(hibernate_active), 16'h0001);
		while (!dram_keepalive_strobe && w < 2 * PER) begin
			@(negedge clk_sys);
			w++;
		end
		while (dram_keepalive_strobe && hi < PER) begin
			@(negedge clk_sys);
			hi++;
		end
		while (!dram_keepalive_strobe && lo < PER) begin
			@(negedge clk_sys);
			lo++;
		end
		chk(16'(hi), 16'(PUL));
		chk(16'(lo), 16'(PER - PUL));
		repeat (SLOW_SETTLE) @(negedge clk_sys);
		t_clocks(1'b1, 1600);
	endtask
	task automatic t_exit();
		send(CODE_EXIT_HIB);
		chk(16'({hibernate_active, dram_keepalive_strobe}), 16'h0000);
		repeat (SLOW_SETTLE) @(negedge clk_sys);
		t_clocks(1'b0, 300);
	endtask
	// reset in mid-run from hibernation must bring back normal mode at once
	task automatic t_mid_reset();
		send(CODE_ENTER_HIB);
		chk(16'(hibernate_active), 16'h0001);
		rst = 1'b1;
		t_reset();
		t_clocks(1'b0, 300);
	endtask
	initial begin
		t_reset();
		t_clocks(1'b0, 300);
		t_enter();
		t_exit();
		t_mid_reset();
		complete_run();
	end
endmodule
